// ===== rtl/sac_consts.svh
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH
`define SAC_MODE_BIT       3
`define SAC_PIN_CH4_BIT    0
`define SAC_PIN_CH5_BIT    1
`define SAC_PIN_CH67_BIT   2
`define SAC_IRQ_SEL_BIT    2
`define SAC_CONV_CYCLES    7'h3e
`define SAC_CMP_CYCLES     7'h08
`define SAC_STEP_CYCLES    7'h06
`define SAC_FIRST_STEP     7'h02
`define SAC_MSB_MASK       10'h200
`define SAC_ZERO10         10'h000
`define SAC_ZERO8          8'h00
`define SAC_ZERO4          4'h0
`define SAC_ZERO3          3'h0
`define SAC_ZERO7          7'h00
`define SAC_ONE7           7'h01
`endif

// ===== rtl/sac_pkg.sv
package sac_pkg;
   typedef enum logic [1:0] {
      SAC_IDLE,
      SAC_CONV,
      SAC_CMP
   } sac_state_t;
endpackage

// ===== rtl/sac_cycle_div.sv
`timescale 1ns/100ps
`default_nettype none
// Machine cycle enable: one core_clk pulse per machine cycle
module sac_cycle_div #(
   parameter int unsigned DIV = 3
) (
   input  wire logic core_clk,
   input  wire logic reset_n,
   output logic      mc_tick
);
   logic [7:0] cnt;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt     <= 8'h00;
         mc_tick <= 1'b0;
      end else if (cnt == 8'(DIV - 1)) begin
         cnt     <= 8'h00;
         mc_tick <= 1'b1;
      end else begin
         cnt     <= cnt + 8'h01;
         mc_tick <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== rtl/sac_adc.sv
// Behaviour
// RQ1 - Mode bit three selects conversion or compare
// RQ2 - Ten-bit result; upper eight to B,A
// RQ3 - Low two bits to A top, zeros
// RQ4 - Software avoids lower read during conversion
// RQ5 - Conversion DAC driven by result value
// RQ6 - Start converts, result stored automatically
// RQ7 - Clear result, set MSB, compare
// RQ8 - Keep bit if reference below input
// RQ9 - Done after 62 cycles, flag set
// RQ10 - Flag cleared by interrupt taken or skip
// RQ11 - Channel select routes one analog input
// RQ12 - Bit zero makes pin analog
// RQ13 - Software writes mode before channel select
// RQ14 - Analog pins keep port; latch one
// RQ15 - Threshold load: B high, A low
// RQ16 - Threshold access only in compare mode
// RQ17 - Compare DAC driven by threshold value
// RQ18 - Compare ends after 8; flag if below
// RQ19 - Software keeps mode stable while busy
// RQ20 - Clear irq select before leaving compare
// RQ21 - Channel field binary selects zero to seven
// RQ22 - Bits one, two assign channels five..seven
// RQ23 - Control registers reset to zero
// RQ24 - Ten steps evenly spread over 62 cycles
// RQ25 - Start while busy restarts operation
`timescale 1ns/100ps
`default_nettype none
`include "sac_consts.svh"
module sac_adc (
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   input  wire logic       start_op,
   input  wire logic       read_upper_op,
   input  wire logic       read_lower_op,
   input  wire logic       write_threshold_op,
   input  wire logic       read_threshold_op,
   input  wire logic       skip_if_done_op,
   input  wire logic       irq_taken,
   input  wire logic       input_select_wr,
   input  wire logic       adc_mode_pin_wr,
   input  wire logic [3:0] acc_a_in,
   input  wire logic [3:0] acc_b_in,
   input  wire logic [3:0] irq_control_reg2,
   input  wire logic       cmp_above,
   input  wire logic       large_package,
   output logic [3:0]      acc_a_out,
   output logic [3:0]      acc_b_out,
   output logic            acc_load,
   output logic            skip_taken,
   output logic            done_flag,
   output logic            irq_request,
   output logic            busy,
   output logic [9:0]      dac_code,
   output logic            dac_wide,
   output logic [2:0]      channel_sel,
   output logic [3:0]      adc_mode_pin_reg,
   output logic [3:0]      input_select_reg,
   output logic [3:0]      analog_pin_en
);
   import sac_pkg::*;

   sac_state_t state;
   logic       mc_tick;
   logic [6:0] mcycle;
   logic [9:0] result_reg;
   logic [9:0] trial_mask;
   logic [7:0] threshold;
   logic       cmp_mode;
   logic       finish;
   logic       set_done;
   logic       clr_done;

   // Channel existence: upper four only on larger package
   function automatic logic channel_ok(input logic [2:0] ch, input logic big);
      channel_ok = big || !ch[2];
   endfunction

   sac_cycle_div u_div (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .mc_tick  (mc_tick)
   );

   assign cmp_mode = adc_mode_pin_reg[`SAC_MODE_BIT]; // [RQ1]

   // Control registers, zero at reset, loaded from acc_a_in on write, retained otherwise
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         adc_mode_pin_reg <= `SAC_ZERO4; // [RQ23]
         input_select_reg <= `SAC_ZERO4; // [RQ23]
      end else begin
         if (adc_mode_pin_wr)
            adc_mode_pin_reg <= acc_a_in;
         if (input_select_wr)
            input_select_reg <= acc_a_in;
      end
   end

   // Pin functions; analog pins stay ports too, so port logic untouched
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         analog_pin_en <= `SAC_ZERO4;
      end else begin
         analog_pin_en[0] <= adc_mode_pin_reg[`SAC_PIN_CH4_BIT]; // [RQ12] [RQ14]
         analog_pin_en[1] <= adc_mode_pin_reg[`SAC_PIN_CH5_BIT]; // [RQ22]
         analog_pin_en[2] <= adc_mode_pin_reg[`SAC_PIN_CH67_BIT]; // [RQ22]
         analog_pin_en[3] <= adc_mode_pin_reg[`SAC_PIN_CH67_BIT]; // [RQ22]
      end
   end

   // Unavailable channel falls back to channel zero
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n)
         channel_sel <= `SAC_ZERO3;
      else if (channel_ok(input_select_reg[2:0], large_package))
         channel_sel <= input_select_reg[2:0]; // [RQ11] [RQ21]
      else
         channel_sel <= `SAC_ZERO3; // [RQ11]
   end

   assign finish = mc_tick && (
      (state == SAC_CONV && mcycle == `SAC_CONV_CYCLES - `SAC_ONE7) ||
      (state == SAC_CMP && mcycle == `SAC_CMP_CYCLES - `SAC_ONE7));

   // Sequencer; a start while busy restarts from the first step
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state  <= SAC_IDLE;
         mcycle <= `SAC_ZERO7;
      end else if (start_op) begin
         state  <= cmp_mode ? SAC_CMP : SAC_CONV; // [RQ6] [RQ25]
         mcycle <= `SAC_ZERO7;
      end else begin
         case (state)
            SAC_IDLE: mcycle <= `SAC_ZERO7;
            SAC_CONV, SAC_CMP: begin
               if (finish) begin
                  state  <= SAC_IDLE; // [RQ9] [RQ18]
                  mcycle <= `SAC_ZERO7;
               end else if (mc_tick) begin
                  mcycle <= mcycle + `SAC_ONE7;
               end
            end
            default: state <= SAC_IDLE;
         endcase
      end
   end

   // Successive approximation: step every SAC_STEP_CYCLES, first at cycle 7, last at cycle 61
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         result_reg <= `SAC_ZERO10;
         trial_mask <= `SAC_ZERO10;
      end else if (start_op && !cmp_mode) begin
         result_reg <= `SAC_MSB_MASK; // [RQ7]
         trial_mask <= `SAC_MSB_MASK; // [RQ7]
      end else if (state == SAC_CONV && mc_tick && trial_mask != `SAC_ZERO10 &&
                   mcycle >= `SAC_FIRST_STEP &&
                   (mcycle - `SAC_FIRST_STEP) % `SAC_STEP_CYCLES ==
                   `SAC_STEP_CYCLES - `SAC_ONE7) begin // [RQ24]
         // Reference above input drops the trial bit
         if (cmp_above)
            result_reg <= (result_reg & ~trial_mask) | (trial_mask >> 1); // [RQ8]
         else
            result_reg <= result_reg | (trial_mask >> 1); // [RQ8]
         trial_mask <= trial_mask >> 1;
      end
   end

   // Threshold kept across modes; writable only in compare mode
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n)
         threshold <= `SAC_ZERO8;
      else if (write_threshold_op && cmp_mode)
         threshold <= {acc_b_in, acc_a_in}; // [RQ15] [RQ16]
   end

   // DAC source follows mode
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         dac_code <= `SAC_ZERO10;
         dac_wide <= 1'b1;
      end else if (cmp_mode) begin
         dac_code <= {2'h0, threshold}; // [RQ17]
         dac_wide <= 1'b0;
      end else begin
         dac_code <= result_reg; // [RQ5]
         dac_wide <= 1'b1;
      end
   end

   // Reference above input means the input sits below the threshold
   assign set_done = finish && (state == SAC_CONV || cmp_above); // [RQ9] [RQ18]
   assign clr_done = irq_taken || (skip_if_done_op && done_flag);

   // Set wins over clear in the same cycle
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n)
         done_flag <= 1'b0;
      else if (set_done)
         done_flag <= 1'b1; // [RQ9] [RQ18]
      else if (clr_done)
         done_flag <= 1'b0; // [RQ10]
   end

   // Request routed to interrupt only when selected in irq_control_reg2
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n)
         irq_request <= 1'b0;
      else
         irq_request <= irq_control_reg2[`SAC_IRQ_SEL_BIT] && (set_done ||
                        (done_flag && !clr_done)); // [RQ10] [RQ20]
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         skip_taken <= 1'b0;
         busy       <= 1'b0;
      end else begin
         skip_taken <= skip_if_done_op && done_flag; // [RQ10]
         busy       <= (state != SAC_IDLE && !finish) || start_op;
      end
   end

   // Accumulator transfers
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         acc_a_out <= `SAC_ZERO4;
         acc_b_out <= `SAC_ZERO4;
         acc_load  <= 1'b0;
      end else begin
         acc_load <= read_upper_op || read_lower_op ||
                     (read_threshold_op && cmp_mode);
         if (read_upper_op) begin
            acc_b_out <= result_reg[9:6]; // [RQ2]
            acc_a_out <= result_reg[5:2]; // [RQ2]
         end else if (read_lower_op) begin
            acc_a_out <= {result_reg[1:0], 2'h0}; // [RQ3]
         end else if (read_threshold_op && cmp_mode) begin
            acc_b_out <= threshold[7:4]; // [RQ16]
            acc_a_out <= threshold[3:0]; // [RQ16]
         end
      end
   end

   conv_len_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      (start_op && !cmp_mode) ##1 (!start_op && !adc_mode_pin_wr) [*8] |->
      state == SAC_CONV) else $error("conversion ended early"); // [RQ9]
   done_set_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      set_done |=> done_flag) else $error("done flag not set"); // [RQ9]
   skip_clr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      (skip_if_done_op && done_flag && !set_done) |=> !done_flag && skip_taken)
      else $error("skip did not clear flag"); // [RQ10]
   lower_rd_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      read_lower_op && !read_upper_op |=> acc_a_out == {$past(result_reg[1:0]), 2'h0})
      else $error("lower read wrong"); // [RQ3]
   upper_rd_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      read_upper_op |=> acc_b_out == $past(result_reg[9:6]) &&
      acc_a_out == $past(result_reg[5:2])) else $error("upper read wrong"); // [RQ2]
   thr_wr_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      write_threshold_op && !cmp_mode |=> $stable(threshold))
      else $error("threshold written outside compare"); // [RQ16]
   conv_clear_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      start_op && !cmp_mode |=> result_reg == `SAC_MSB_MASK)
      else $error("conversion did not clear result"); // [RQ7]
   dac_src_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      cmp_mode && $stable(cmp_mode) && $stable(threshold) |=> dac_code[9:8] == 2'h0)
      else $error("compare dac source wrong"); // [RQ17]
   chan_a: assert property (@(posedge core_clk) disable iff (!reset_n)
      !large_package |=> !channel_sel[2] || $past(large_package))
      else $error("absent channel routed"); // [RQ11]
   // All ten steps must be used up by the last machine cycle
   all_steps_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ24]
      finish && state == SAC_CONV && !start_op |=> trial_mask == `SAC_ZERO10)
      else $error("conversion ended before last step");
   cmp_hit_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ18]
      finish && state == SAC_CMP && cmp_above |=> done_flag)
      else $error("compare hit not flagged");
   cmp_miss_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ18]
      finish && state == SAC_CMP && !cmp_above && !done_flag |=> !done_flag)
      else $error("compare miss flagged");
   irq_clr_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ10]
      irq_taken && !set_done |=> !done_flag)
      else $error("interrupt did not clear flag");
   irq_route_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ10]
      !irq_control_reg2[`SAC_IRQ_SEL_BIT] |=> !irq_request)
      else $error("request raised while skip selected");
   restart_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ25]
      start_op |=> busy && mcycle == `SAC_ZERO7 && state != SAC_IDLE)
      else $error("start did not begin from first step");
   thr_rd_a: assert property (@(posedge core_clk) disable iff (!reset_n) // [RQ16]
      read_threshold_op && !cmp_mode && !read_upper_op && !read_lower_op |=> !acc_load)
      else $error("threshold read outside compare");

   conv_done_c: cover property (@(posedge core_clk) disable iff (!reset_n)
      finish && state == SAC_CONV);
   cmp_hit_c: cover property (@(posedge core_clk) disable iff (!reset_n)
      finish && state == SAC_CMP && cmp_above);
   cmp_miss_c: cover property (@(posedge core_clk) disable iff (!reset_n)
      finish && state == SAC_CMP && !cmp_above);
   restart_c: cover property (@(posedge core_clk) disable iff (!reset_n)
      start_op && state != SAC_IDLE);
endmodule
`default_nettype wire

// ===== verif/sac_analog_model.sv
`timescale 1ns/100ps
`default_nettype none
// Analog side: input mux plus reference DAC, compared ideally
module sac_analog_model (
   input  wire logic [9:0]  dac_code,
   input  wire logic        dac_wide,
   input  wire logic [2:0]  channel_sel,
   input  wire logic [79:0] vin_bus,
   output logic             cmp_above
);
   logic [9:0] vin;
   logic [9:0] vref;
   assign vin = vin_bus[channel_sel*10 +: 10];
   // Narrow scale is 256 steps of the same supply
   assign vref = dac_wide ? dac_code : {dac_code[7:0], 2'b00};
   assign cmp_above = vref > vin;
endmodule
`default_nettype wire

// ===== verif/sar_adc_and_threshold_compare_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sar_adc_and_threshold_compare_tb;
   logic        core_clk, reset_n, cmp_above, acc_load, skip_taken, large_pkg;
   logic        done_flag, irq_request, busy, dac_wide, got_load, got_skip;
   logic [8:0]  ops;
   logic [3:0]  acc_a, acc_b, irq_ctl, a_out, b_out, mode_reg, sel_reg, pin_en;
   logic [79:0] vin_bus;
   logic [9:0]  dac_code;
   logic [2:0]  channel_sel;
   logic [7:0]  got_val, t;
   logic [9:0]  v;
   int          bad_count, checks, n, i;
   sac_adc dut_u (.core_clk(core_clk), .reset_n(reset_n), .start_op(ops[0]),
      .read_upper_op(ops[1]), .read_lower_op(ops[2]), .write_threshold_op(ops[3]),
      .read_threshold_op(ops[4]), .skip_if_done_op(ops[5]), .irq_taken(ops[6]),
      .input_select_wr(ops[7]), .adc_mode_pin_wr(ops[8]), .acc_a_in(acc_a),
      .acc_b_in(acc_b), .irq_control_reg2(irq_ctl), .cmp_above(cmp_above),
      .large_package(large_pkg), .acc_a_out(a_out), .acc_b_out(b_out), .acc_load(acc_load),
      .skip_taken(skip_taken), .done_flag(done_flag), .irq_request(irq_request),
      .busy(busy), .dac_code(dac_code), .dac_wide(dac_wide), .channel_sel(channel_sel),
      .adc_mode_pin_reg(mode_reg), .input_select_reg(sel_reg), .analog_pin_en(pin_en));
   sac_analog_model far_u (.dac_code(dac_code), .dac_wide(dac_wide),
      .channel_sel(channel_sel), .vin_bus(vin_bus), .cmp_above(cmp_above));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic op(input int k, input logic [3:0] a, input logic [3:0] b);
      @(posedge core_clk);
      ops   <= 9'h001 << k;
      acc_a <= a;
      acc_b <= b;
      @(posedge core_clk);
      ops <= 9'h000;
   endtask
   // Answers may land on the taking edge or up to two later
   task automatic act(input int k, input logic [3:0] a, input logic [3:0] b);
      int j;
      op(k, a, b);
      got_load = 1'b0;
      got_skip = 1'b0;
      got_val  = 8'hxx;
      for (j = 0; j < 3; j++) begin
         #1;
         if (skip_taken === 1'b1) got_skip = 1'b1;
         if (acc_load === 1'b1) begin
            got_load = 1'b1;
            got_val  = {b_out, a_out};
         end
         @(posedge core_clk);
      end
   endtask
   task automatic wait_idle();
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (busy !== 1'b0 && n < 400);
      if (n >= 400) begin
         chk("busy timeout", 16'h0, 16'h1);
         end_sim();
      end
   endtask
   task automatic conv(input logic [2:0] ch, input logic [9:0] x, input bit twice);
      @(posedge core_clk);
      vin_bus[ch*10 +: 10] <= x;
      op(7, {1'b0, ch}, 4'h0);
      op(0, 4'h0, 4'h0);
      if (twice) begin
         repeat (40) @(posedge core_clk);
         op(0, 4'h0, 4'h0);
      end
      wait_idle();
      chk("conv cycles", 1, n >= 180 && n <= 192);
      chk("done", 1, done_flag);
      chk("irq off", 0, irq_request);
      chk("channel", ch, channel_sel);
      act(1, 4'h0, 4'h0);
      chk("upper", x[9:2], got_val);
      act(2, 4'h0, 4'h0);
      chk("lower", {x[1:0], 2'b00}, got_val[3:0]);
      act(5, 4'h0, 4'h0);
      chk("skip", 1, got_skip);
      chk("done clr", 0, done_flag);
      act(5, 4'h0, 4'h0);
      chk("no skip", 0, got_skip);
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      reset_n = 1'b0;
      ops = 9'h000;
      acc_a = 4'h0;
      acc_b = 4'h0;
      irq_ctl = 4'h0;
      large_pkg = 1'b1;
      vin_bus = 80'h0;
      bad_count = 0;
      checks = 0;
      void'($urandom(32'h8548));
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      #1;
      chk("reset", 16'h0001, {done_flag, busy, mode_reg, sel_reg, dac_wide});
      op(8, 4'h7, 4'h0);
      @(posedge core_clk);
      #1;
      chk("mode reg", 4'h7, mode_reg);
      conv(3'h0, 10'h000, 0);
      conv(3'h7, 10'h3ff, 1);
      for (i = 0; i < 6; i++) conv(3'($urandom % 8), 10'($urandom % 1024), i == 2);
      op(8, 4'hf, 4'h0);
      op(7, 4'h0, 4'h0);
      for (i = 0; i < 6; i++) begin
         t = 8'($urandom);
         v = (i == 0) ? {t, 2'b00} : 10'($urandom % 1024);
         irq_ctl <= (i % 2) ? 4'h4 : 4'h0;
         vin_bus[9:0] <= v;
         act(3, t[3:0], t[7:4]);
         act(4, 4'h0, 4'h0);
         chk("threshold", t, got_val);
         op(0, 4'h0, 4'h0);
         wait_idle();
         chk("cmp cycles", 1, n >= 20 && n <= 30);
         chk("cmp flag", {t, 2'b00} > v, done_flag);
         if (i % 2) begin
            chk("irq", {t, 2'b00} > v, irq_request);
            act(6, 4'h0, 4'h0);
         end else act(5, 4'h0, 4'h0);
         chk("flag clr", 0, done_flag);
      end
      irq_ctl <= 4'h0;
      op(8, 4'h7, 4'h0);
      act(5, 4'h0, 4'h0);
      act(3, ~t[3:0], ~t[7:4]);
      op(8, 4'hf, 4'h0);
      act(4, 4'h0, 4'h0);
      chk("thr kept", t, got_val);
      op(8, 4'h7, 4'h0);
      act(5, 4'h0, 4'h0);
      conv(3'h5, 10'h2a5, 0);
      large_pkg <= 1'b0;
      op(7, 4'h5, 4'h0);
      @(posedge core_clk);
      #1;
      chk("absent chan", 0, channel_sel);
      end_sim();
   end
endmodule
`default_nettype wire
